/* inc/adapter_dma_defs.vh */
// Purpose: register offsets, field positions and timing counts of the adapter DMA control
// Assumes: byte-wide I/O register port, 10 MHz core clock
// Notes:   offsets are byte offsets from the I/O window base
`ifndef ADAPTER_DMA_DEFS_VH
`define ADAPTER_DMA_DEFS_VH

// -----------------------------------------------------------------
// register offsets
// -----------------------------------------------------------------
`define OFF_REMOTE_CMD1       5'h08
`define OFF_REMOTE_MODE       5'h09
`define OFF_FAR_CARD_ID       5'h0c
`define OFF_DMA_MODIFIER      5'h0d
`define OFF_IACK_LOW          5'h0e
`define OFF_IACK_HIGH         5'h0f
`define OFF_LOCAL_CMD         5'h10
`define OFF_LOCAL_REMAINDER   5'h11
`define OFF_PACKETS_LOW       5'h12
`define OFF_PACKETS_HIGH      5'h13
`define OFF_HOST_ADDR_LOW     5'h14
`define OFF_HOST_ADDR_MID     5'h15
`define OFF_HOST_ADDR_HIGH    5'h16
`define OFF_REMOTE_REMAINDER  5'h18
`define OFF_VME_ADDR_B2       5'h1a
`define OFF_VME_ADDR_B3       5'h1b
`define OFF_VME_ADDR_B0       5'h1c
`define OFF_VME_ADDR_B1       5'h1d
`define OFF_TARGET_ERR        5'h1e

// -----------------------------------------------------------------
// field positions
// -----------------------------------------------------------------
`define MODE_PAUSE_BIT        7
`define MODE_BLOCK_BIT        5
`define MODE_NOIRQ_BIT        4
`define CMD_START_BIT         7
`define CMD_ROUTE_BIT         6
`define CMD_DIR_BIT           5
`define CMD_WIDTH_BIT         4
`define CMD_DONE_IE_BIT       2
`define CMD_DONE_BIT          1
`define CMD_ACTIVE_BIT        0
`define ERR_TIMEOUT_BIT       0
`define ERR_BUSERR_BIT        1
`define ERR_CLEAR_BIT         7

// -----------------------------------------------------------------
// reset values and constants
// -----------------------------------------------------------------
`define RESET_BYTE            8'h00
`define FAR_CARD_CODE         8'h5a // arbitrary value, not a real card code
`define BLOCK_TENURE_BYTES    9'h100
`define PAUSE_TENURE_BYTES    9'h040
`define CLK_HZ                10000000
`define DMA_LIMIT_MS          16
`define DMA_LIMIT_CYCLES      ((`CLK_HZ / 1000) * `DMA_LIMIT_MS)

`endif

/* hdl/bus_adapter_dma_control.v */
// Purpose: register file and DMA sequencer of the PCI-to-VMEbus adapter pair
// Assumes: one host access per cycle, inputs synchronous to core_clk
// Notes:   one VMEbus beat is taken per beatDone pulse from the data path
`timescale 1ns/1ps
`include "adapter_dma_defs.vh"

// How it works
// - pause mode: re-arbitrate after 64 bytes
// - pause ignored unless block mode set
// - block mode: re-arbitrate after 256 bytes
// - interrupt passing disable blocks remote interrupts
// - identifier reads fixed code, writes ignored
// - modifier driven only during DMA transfers
// - IACK read launches acknowledge cycle with level
// - each IACK read while none pending gets own cycle, errors reported
// - start bit begins DMA, clears at end
// - 16 ms timeout aborts, sets error
// - route bit selects dual-port RAM or VMEbus
// - direction bit selects PCI-to-VME or back
// - width bit selects four or two bytes
// - done interrupt needs both enables
// - done flag holds, zero write or next start clears
// - active bit shows any DMA running
// - packet count decrements, reads remaining
// - host address steps by transfer width
module bus_adapter_dma_control #(
  parameter DMA_LIMIT = `DMA_LIMIT_CYCLES
) (
  // clock and reset
  input  wire        core_clk,
  input  wire        rst,
  // host register port
  input  wire [4:0]  regAddr,
  input  wire        regWrite,
  input  wire        regRead,
  input  wire        regWordRead,
  input  wire [7:0]  regWrData,
  output reg  [15:0] regRdData,
  // system side
  input  wire        normalIrqEnable,
  input  wire        remoteIrqIn,
  input  wire        remoteDmaBusy,
  output reg         remoteIrqOut,
  output reg         doneIrq,
  // VMEbus data path
  input  wire        beatDone,
  input  wire        vmeBusError,
  input  wire        ackDone,
  input  wire [15:0] ackVector,
  output reg         vmeRequest,
  output reg         vmeIack,
  output reg  [2:0]  vmeIackLevel,
  output reg  [7:0]  vmeModifier,
  output reg         dualPortRoute,
  output reg         toVme,
  output reg         longWidth,
  output reg  [31:0] vmeAddr,
  output reg  [23:0] hostAddr
);

  localparam ST_IDLE  = 2'd0;
  localparam ST_XFER  = 2'd1;
  localparam ST_PAUSE = 2'd2;

  reg [7:0]  cmdOne;
  reg [7:0]  remote_dma_mode_control;
  reg [7:0]  dma_vme_modifier;
  reg [7:0]  local_dma_remainder;
  reg [7:0]  remote_dma_remainder;
  reg [15:0] packetCount;
  reg [7:0]  errStatus;
  reg        startBit;
  reg        dualPortSel;
  reg        dirSel;
  reg        widthSel;
  reg        doneIe;
  reg        doneFlag;
  reg        localActive;
  reg [1:0]  state;
  reg [8:0]  tenureBytes;
  reg [8:0]  leftInPacket;
  reg [31:0] timer;
  reg        ackBusy;
  reg [15:0] next_rd;

  wire       blockMode = remote_dma_mode_control[`MODE_BLOCK_BIT];
  wire       pauseMode = remote_dma_mode_control[`MODE_PAUSE_BIT] & blockMode;
  wire [8:0] beatBytes = widthSel ? 9'd4 : 9'd2;
  wire [8:0] tenureCap = pauseMode ? `PAUSE_TENURE_BYTES : `BLOCK_TENURE_BYTES;
  wire       wrCmd     = regWrite && (regAddr == `OFF_LOCAL_CMD);
  wire       startReq  = wrCmd && regWrData[`CMD_START_BIT] && !localActive;
  wire       lastBeat  = (packetCount == 16'h0000) &&
                         (leftInPacket <= beatBytes);
  wire       timedOut  = (timer >= DMA_LIMIT - 1);

  // decode a register write to one byte offset
  function hit;
    input [4:0] addr;
    input [4:0] off;
    begin
      hit = regWrite && (addr == off);
    end
  endfunction

  // -----------------------------------------------------------------
  // read mux
  // -----------------------------------------------------------------
  always @* begin
    next_rd = 16'h0000;
    case (regAddr)
      `OFF_REMOTE_MODE:      next_rd[7:0] = remote_dma_mode_control;
      `OFF_FAR_CARD_ID:      next_rd[7:0] = `FAR_CARD_CODE;
      `OFF_DMA_MODIFIER:     next_rd[7:0] = dma_vme_modifier;
      `OFF_LOCAL_CMD:        next_rd[7:0] = {startBit, dualPortSel, dirSel, widthSel,
                                             1'b0, doneIe, doneFlag,
                                             localActive | remoteDmaBusy};
      `OFF_LOCAL_REMAINDER:  next_rd[7:0] = local_dma_remainder;
      `OFF_PACKETS_LOW:      next_rd = packetCount;
      `OFF_PACKETS_HIGH:     next_rd[7:0] = packetCount[15:8];
      `OFF_HOST_ADDR_LOW:    next_rd[7:0] = hostAddr[7:0];
      `OFF_HOST_ADDR_MID:    next_rd[7:0] = hostAddr[15:8];
      `OFF_HOST_ADDR_HIGH:   next_rd[7:0] = hostAddr[23:16];
      `OFF_REMOTE_REMAINDER: next_rd[7:0] = remote_dma_remainder;
      `OFF_VME_ADDR_B2:      next_rd[7:0] = vmeAddr[23:16];
      `OFF_VME_ADDR_B3:      next_rd[7:0] = vmeAddr[31:24];
      `OFF_VME_ADDR_B0:      next_rd[7:0] = vmeAddr[7:0];
      `OFF_VME_ADDR_B1:      next_rd[7:0] = vmeAddr[15:8];
      `OFF_TARGET_ERR:       next_rd[7:0] = errStatus;
      default:               next_rd = 16'h0000;
    endcase
  end

  // -----------------------------------------------------------------
  // registers and sequencer
  // -----------------------------------------------------------------
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cmdOne                  <= `RESET_BYTE;
      remote_dma_mode_control <= `RESET_BYTE;
      dma_vme_modifier        <= `RESET_BYTE;
      local_dma_remainder     <= `RESET_BYTE;
      remote_dma_remainder    <= `RESET_BYTE;
      packetCount             <= 16'h0000;
      errStatus               <= `RESET_BYTE;
      startBit                <= 1'b0;
      dualPortSel             <= 1'b0;
      dirSel                  <= 1'b0;
      widthSel                <= 1'b0;
      doneIe                  <= 1'b0;
      doneFlag                <= 1'b0;
      localActive             <= 1'b0;
      state                   <= ST_IDLE;
      tenureBytes             <= 9'h000;
      leftInPacket            <= 9'h000;
      timer                   <= 32'h0000_0000;
      ackBusy                 <= 1'b0;
      regRdData               <= 16'h0000;
      remoteIrqOut            <= 1'b0;
      doneIrq                 <= 1'b0;
      vmeRequest              <= 1'b0;
      vmeIack                 <= 1'b0;
      vmeIackLevel            <= 3'h0;
      vmeModifier             <= 8'h00;
      dualPortRoute           <= 1'b0;
      toVme                   <= 1'b0;
      longWidth               <= 1'b0;
      vmeAddr                 <= 32'h0000_0000;
      hostAddr                <= 24'h00_0000;
    end else begin
      regRdData <= next_rd;
      // plain register writes; the identifier has no write path
      if (hit(regAddr, `OFF_REMOTE_CMD1))      cmdOne <= regWrData;
      if (hit(regAddr, `OFF_REMOTE_MODE))      remote_dma_mode_control <= regWrData;
      if (hit(regAddr, `OFF_DMA_MODIFIER))     dma_vme_modifier <= regWrData;
      if (hit(regAddr, `OFF_LOCAL_REMAINDER))  local_dma_remainder <= regWrData;
      if (hit(regAddr, `OFF_REMOTE_REMAINDER)) remote_dma_remainder <= regWrData;
      if (hit(regAddr, `OFF_PACKETS_LOW))      packetCount[7:0] <= regWrData;
      if (hit(regAddr, `OFF_PACKETS_HIGH))     packetCount[15:8] <= regWrData;
      if (hit(regAddr, `OFF_HOST_ADDR_LOW))    hostAddr[7:0] <= regWrData;
      if (hit(regAddr, `OFF_HOST_ADDR_MID))    hostAddr[15:8] <= regWrData;
      if (hit(regAddr, `OFF_HOST_ADDR_HIGH))   hostAddr[23:16] <= regWrData;
      if (hit(regAddr, `OFF_VME_ADDR_B2))      vmeAddr[23:16] <= regWrData;
      if (hit(regAddr, `OFF_VME_ADDR_B3))      vmeAddr[31:24] <= regWrData;
      if (hit(regAddr, `OFF_VME_ADDR_B0))      vmeAddr[7:0] <= regWrData;
      if (hit(regAddr, `OFF_VME_ADDR_B1))      vmeAddr[15:8] <= regWrData;
      if (hit(regAddr, `OFF_TARGET_ERR) && regWrData[`ERR_CLEAR_BIT])
        errStatus <= `RESET_BYTE;

      // command writes, mode bits frozen while running
      if (wrCmd && !localActive) begin
        dualPortSel <= regWrData[`CMD_ROUTE_BIT];
        dirSel      <= regWrData[`CMD_DIR_BIT];
        widthSel    <= regWrData[`CMD_WIDTH_BIT];
        doneIe      <= regWrData[`CMD_DONE_IE_BIT];
      end
      if (wrCmd && !regWrData[`CMD_DONE_BIT]) begin
        doneFlag <= 1'b0;
        doneIrq  <= 1'b0;
      end

      // interrupt forwarding gate
      remoteIrqOut <= remoteIrqIn & ~remote_dma_mode_control[`MODE_NOIRQ_BIT];

      // acknowledge cycle per read of the low register while none is pending
      if (!ackBusy && regRead && (regAddr == `OFF_IACK_LOW)) begin
        ackBusy      <= 1'b1;
        vmeIack      <= 1'b1;
        vmeIackLevel <= cmdOne[2:0];
      end else if (ackBusy && (ackDone || vmeBusError)) begin
        ackBusy <= 1'b0;
        vmeIack <= 1'b0;
        if (vmeBusError)
          errStatus[`ERR_BUSERR_BIT] <= 1'b1;
      end

      // DMA sequencer
      case (state)
        ST_IDLE: begin
          vmeRequest  <= 1'b0;
          vmeModifier <= 8'h00;
          if (startReq) begin
            startBit      <= 1'b1;
            localActive   <= 1'b1;
            doneFlag      <= 1'b0;
            doneIrq       <= 1'b0;
            timer         <= 32'h0000_0000;
            tenureBytes   <= 9'h000;
            // a zero remainder starts straight on a full packet
            if (local_dma_remainder == 8'h00) begin
              leftInPacket <= 9'h100;
              packetCount  <= packetCount - 16'h0001;
            end else begin
              leftInPacket <= {1'b0, local_dma_remainder};
            end
            dualPortRoute <= regWrData[`CMD_ROUTE_BIT];
            toVme         <= regWrData[`CMD_DIR_BIT];
            longWidth     <= regWrData[`CMD_WIDTH_BIT];
            vmeModifier   <= dma_vme_modifier;
            vmeRequest    <= 1'b1;
            state         <= ST_XFER;
          end
        end
        ST_XFER: begin
          timer <= timer + 32'd1;
          if (timedOut) begin
            errStatus[`ERR_TIMEOUT_BIT] <= 1'b1;
            startBit    <= 1'b0;
            localActive <= 1'b0;
            vmeRequest  <= 1'b0;
            vmeModifier <= 8'h00;
            state       <= ST_IDLE;
          end else if (beatDone) begin
            hostAddr <= hostAddr + {15'h0000, beatBytes};
            vmeAddr  <= vmeAddr + {23'h00_0000, beatBytes};
            // chunk used up: reload a full 256-byte packet if any remain
            if (leftInPacket <= beatBytes) begin
              if (packetCount != 16'h0000) begin
                packetCount  <= packetCount - 16'h0001;
                leftInPacket <= 9'h100;
              end
            end else begin
              leftInPacket <= leftInPacket - beatBytes;
            end
            if (lastBeat) begin
              startBit    <= 1'b0;
              localActive <= 1'b0;
              doneFlag    <= 1'b1;
              doneIrq     <= doneIe & normalIrqEnable;
              vmeRequest  <= 1'b0;
              vmeModifier <= 8'h00;
              state       <= ST_IDLE;
            end else if (blockMode && (tenureBytes + beatBytes >= tenureCap)) begin
              tenureBytes <= 9'h000;
              vmeRequest  <= 1'b0;
              state       <= ST_PAUSE;
            end else begin
              tenureBytes <= blockMode ? tenureBytes + beatBytes : 9'h000;
            end
          end
        end
        ST_PAUSE: begin
          // one idle cycle with the request dropped lets others win arbitration
          timer      <= timer + 32'd1;
          vmeRequest <= 1'b1;
          state      <= ST_XFER;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

endmodule // bus_adapter_dma_control

/* verification/bus_adapter_dma_control_props.sv */
// Purpose: assertion checker for the adapter DMA control
// Assumes: one core_clk domain, rst asynchronous active high
// Notes:   mode shadow follows idle-time host writes, IACK level shadow follows every write
`timescale 1ns/1ps
`include "adapter_dma_defs.vh"
module bus_adapter_dma_control_props #(
  parameter DMA_LIMIT = 50
) (
  // clock and reset
  input wire        core_clk,
  input wire        rst,
  // host and system side
  input wire [4:0]  regAddr,
  input wire        regWrite,
  input wire        regRead,
  input wire [7:0]  regWrData,
  input wire        normalIrqEnable,
  input wire        remoteIrqIn,
  input wire        remoteDmaBusy,
  input wire        remoteIrqOut,
  input wire        doneIrq,
  // VMEbus side
  input wire        beatDone,
  input wire        vmeBusError,
  input wire        ackDone,
  input wire        vmeRequest,
  input wire        vmeIack,
  input wire [2:0]  vmeIackLevel,
  input wire [7:0]  vmeModifier,
  input wire        dualPortRoute,
  input wire        toVme,
  input wire        longWidth,
  input wire [23:0] hostAddr
);
  reg  [2:0] lvl;
  reg  [7:0] mode;
  reg  [8:0] ten;
  wire       idle = !vmeRequest && !remoteDmaBusy;
  wire [8:0] cap  = mode[`MODE_PAUSE_BIT] ? `PAUSE_TENURE_BYTES : `BLOCK_TENURE_BYTES;
  wire [8:0] step = longWidth ? 9'h004 : 9'h002;
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      lvl  <= 3'h0;
      mode <= 8'h00;
      ten  <= 9'h000;
    end else begin
      if (regWrite && regAddr == `OFF_REMOTE_CMD1) lvl <= regWrData[2:0];
      if (regWrite && regAddr == `OFF_REMOTE_MODE && idle) mode <= regWrData;
      ten <= !vmeRequest ? 9'h000 : (beatDone ? ten + step : ten);
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  property p_modGate;
    !vmeRequest && !$past(vmeRequest) |-> vmeModifier == 8'h00;
  endproperty
  a_modGate: assert property (p_modGate) else $error("modifier outside DMA");
  property p_iackGo;
    regRead && regAddr == `OFF_IACK_LOW && !vmeIack |=> vmeIack && vmeIackLevel == lvl;
  endproperty
  a_iackGo: assert property (p_iackGo) else $error("IACK cycle not launched");
  property p_iackEnd;
    vmeIack && (ackDone || vmeBusError) |=> !vmeIack;
  endproperty
  a_iackEnd: assert property (p_iackEnd) else $error("IACK not ended");
  property p_start;
    regWrite && regAddr == `OFF_LOCAL_CMD && regWrData[7] && idle && !$past(vmeRequest)
      |=> vmeRequest && {dualPortRoute, toVme, longWidth} == $past(regWrData[6:4]);
  endproperty
  a_start: assert property (p_start) else $error("start not taken");
  property p_tenure;
    vmeRequest && beatDone && mode[`MODE_BLOCK_BIT] |-> ten + step <= cap;
  endproperty
  a_tenure: assert property (p_tenure) else $error("tenure too long");
  property p_step;
    vmeRequest && beatDone |=> hostAddr == $past(hostAddr) + (longWidth ? 24'h4 : 24'h2);
  endproperty
  a_step: assert property (p_step) else $error("host address step wrong");
  property p_doneIrq;
    $rose(doneIrq) |-> $past(vmeRequest) && $past(normalIrqEnable);
  endproperty
  a_doneIrq: assert property (p_doneIrq) else $error("done interrupt ungated");
  property p_doneClr;
    regWrite && regAddr == `OFF_LOCAL_CMD && !regWrData[`CMD_DONE_BIT] && !vmeRequest |=> !doneIrq;
  endproperty
  a_doneClr: assert property (p_doneClr) else $error("done interrupt kept");
  property p_irqGate;
    remoteIrqOut |-> $past(remoteIrqIn) && !$past(mode[`MODE_NOIRQ_BIT]);
  endproperty
  a_irqGate: assert property (p_irqGate) else $error("interrupt passed");
  c_iack: cover property (vmeIack && ackDone);
  c_cap: cover property (vmeRequest && beatDone && ten + step == cap);
  c_done: cover property ($rose(doneIrq));
endmodule // bus_adapter_dma_control_props

bind bus_adapter_dma_control bus_adapter_dma_control_props #(.DMA_LIMIT(DMA_LIMIT)) u_props (
  .core_clk(core_clk), .rst(rst), .regAddr(regAddr), .regWrite(regWrite), .regRead(regRead),
  .regWrData(regWrData), .normalIrqEnable(normalIrqEnable), .remoteIrqIn(remoteIrqIn),
  .remoteDmaBusy(remoteDmaBusy), .remoteIrqOut(remoteIrqOut), .doneIrq(doneIrq),
  .beatDone(beatDone), .vmeBusError(vmeBusError), .ackDone(ackDone), .vmeRequest(vmeRequest),
  .vmeIack(vmeIack), .vmeIackLevel(vmeIackLevel), .vmeModifier(vmeModifier),
  .dualPortRoute(dualPortRoute), .toVme(toVme), .longWidth(longWidth), .hostAddr(hostAddr));

/* verification/vme_backplane_model.sv */
// Purpose: VMEbus backplane stand-in for the adapter DMA engine
// Assumes: beats at most every other cycle, IACK answered three cycles after vmeIack rises
// Notes:   stall holds off beats, badAck answers IACK with a bus error
`timescale 1ns/1ps
module vme_backplane_model (
  // clock and reset
  input  wire        core_clk,
  input  wire        rst,
  // bench controls
  input  wire        stall,
  input  wire        badAck,
  // adapter side
  input  wire        vmeRequest,
  input  wire        vmeIack,
  output reg         beatDone,
  output reg         ackDone,
  output reg         vmeBusError,
  output reg  [15:0] ackVector
);
  reg [1:0] wt;
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      beatDone    <= 1'b0;
      ackDone     <= 1'b0;
      vmeBusError <= 1'b0;
      ackVector   <= 16'h0000;
      wt          <= 2'h0;
    end else begin
      beatDone    <= vmeRequest && !beatDone && !stall;
      wt          <= (vmeIack && !ackDone && !vmeBusError) ? wt + 2'h1 : 2'h0;
      ackDone     <= vmeIack && wt == 2'h2 && !badAck;
      vmeBusError <= vmeIack && wt == 2'h2 && badAck;
      ackVector   <= vmeIack ? 16'h00a5 : ~ackVector;
    end
  end
endmodule // vme_backplane_model

/* verification/bus_adapter_dma_control_tb.sv */
// Purpose: self-checking bench for the adapter DMA control
// Assumes: 10 MHz core clock, DMA limit cut to 2000 cycles
// Notes:   inputs move 1 ns after the rising edge
`timescale 1ns/1ps
`include "adapter_dma_defs.vh"
module bus_adapter_dma_control_tb;
  localparam LIMIT = 2000;
  reg         core_clk, rst, regWrite, regRead, regWordRead, stall, badAck;
  reg  [4:0]  regAddr;
  reg  [7:0]  regWrData, rv;
  reg         normalIrqEnable, remoteIrqIn, remoteDmaBusy;
  wire [15:0] regRdData, ackVector;
  wire        remoteIrqOut, doneIrq, beatDone, vmeBusError, ackDone, vmeRequest, vmeIack;
  wire        dualPortRoute, toVme, longWidth;
  wire [2:0]  vmeIackLevel;
  wire [7:0]  vmeModifier;
  wire [31:0] vmeAddr;
  wire [23:0] hostAddr;
  integer     error_cnt, n_checks, gapCnt;
  bus_adapter_dma_control #(.DMA_LIMIT(LIMIT)) DUT (
    .core_clk(core_clk), .rst(rst), .regAddr(regAddr), .regWrite(regWrite), .regRead(regRead),
    .regWordRead(regWordRead), .regWrData(regWrData), .regRdData(regRdData),
    .normalIrqEnable(normalIrqEnable), .remoteIrqIn(remoteIrqIn), .remoteDmaBusy(remoteDmaBusy),
    .remoteIrqOut(remoteIrqOut), .doneIrq(doneIrq), .beatDone(beatDone),
    .vmeBusError(vmeBusError), .ackDone(ackDone), .ackVector(ackVector), .vmeRequest(vmeRequest),
    .vmeIack(vmeIack), .vmeIackLevel(vmeIackLevel), .vmeModifier(vmeModifier),
    .dualPortRoute(dualPortRoute), .toVme(toVme), .longWidth(longWidth), .vmeAddr(vmeAddr),
    .hostAddr(hostAddr));
  vme_backplane_model u_vme (.core_clk(core_clk), .rst(rst), .stall(stall), .badAck(badAck),
    .vmeRequest(vmeRequest), .vmeIack(vmeIack), .beatDone(beatDone), .ackDone(ackDone),
    .vmeBusError(vmeBusError), .ackVector(ackVector));
  always @(negedge vmeRequest) gapCnt = gapCnt + 1;
  // -----------------------------------------------------------------
  // shared tasks
  // -----------------------------------------------------------------
  task chk(input [31:0] got, input [31:0] exp);
    begin
      n_checks = n_checks + 1;
      if (got !== exp) begin
        error_cnt = error_cnt + 1;
        $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task wr(input [4:0] a, input [7:0] d);
    begin
      @(posedge core_clk);
      #1 regAddr = a;
      regWrData = d;
      regWrite = 1'b1;
      @(posedge core_clk);
      #1 regWrite = 1'b0;
    end
  endtask
  task rd(input [4:0] a, output [7:0] d);
    begin
      @(posedge core_clk);
      #1 regAddr = a;
      regRead = 1'b1;
      @(posedge core_clk);
      #1 regRead = 1'b0;
      d = regRdData[7:0];
    end
  endtask
  task tally_and_finish;
    begin
      if (error_cnt == 0 && n_checks > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask
  // -----------------------------------------------------------------
  // scenarios
  // -----------------------------------------------------------------
  task t_misc;
    begin
      wr(`OFF_FAR_CARD_ID, 8'hff);
      rd(`OFF_FAR_CARD_ID, rv);
      chk(rv, `FAR_CARD_CODE);
      wr(`OFF_LOCAL_REMAINDER, 8'h0c);
      wr(5'h17, 8'hff);
      rd(`OFF_LOCAL_REMAINDER, rv);
      chk(rv, 8'h0c);
      remoteDmaBusy = 1'b1;
      rd(`OFF_LOCAL_CMD, rv);
      chk(rv[0], 1'b1);
      remoteDmaBusy = 1'b0;
      remoteIrqIn = 1'b1;
      wr(`OFF_REMOTE_MODE, 8'h10);
      @(posedge core_clk);
      #1 chk(remoteIrqOut, 1'b0);
      wr(`OFF_REMOTE_MODE, 8'h00);
      @(posedge core_clk);
      #1 chk(remoteIrqOut, 1'b1);
      remoteIrqIn = 1'b0;
    end
  endtask
  task t_iack;
    begin
      wr(`OFF_REMOTE_CMD1, 8'h05);
      rd(`OFF_IACK_LOW, rv);
      chk({vmeIack, vmeIackLevel}, 4'hd);
      repeat (6) @(posedge core_clk);
      #1 chk(vmeIack, 1'b0);
      badAck = 1'b1;
      rd(`OFF_IACK_LOW, rv);
      chk(vmeIack, 1'b1);
      repeat (6) @(posedge core_clk);
      rd(`OFF_TARGET_ERR, rv);
      chk(rv[`ERR_BUSERR_BIT], 1'b1);
      badAck = 1'b0;
      wr(`OFF_TARGET_ERR, 8'h80);
    end
  endtask
  task t_dma(input [7:0] mode, input [7:0] cmd, input [7:0] am);
    integer i;
    begin
      wr(`OFF_REMOTE_MODE, mode | 8'h10);
      wr(`OFF_DMA_MODIFIER, am);
      wr(`OFF_LOCAL_REMAINDER, 8'h08);
      wr(`OFF_REMOTE_REMAINDER, 8'h08);
      wr(`OFF_PACKETS_LOW, 8'h01);
      wr(`OFF_PACKETS_HIGH, 8'h00);
      wr(`OFF_HOST_ADDR_LOW, 8'h00);
      wr(`OFF_HOST_ADDR_MID, 8'h12);
      wr(`OFF_HOST_ADDR_HIGH, 8'h03);
      wr(`OFF_VME_ADDR_B0, 8'h00);
      wr(`OFF_VME_ADDR_B1, 8'h40);
      wr(`OFF_VME_ADDR_B2, 8'h02);
      wr(`OFF_VME_ADDR_B3, 8'h01);
      gapCnt = 0;
      wr(`OFF_LOCAL_CMD, cmd | 8'h80);
      rd(`OFF_LOCAL_CMD, rv);
      chk(rv[0], 1'b1);
      chk(vmeModifier, am);
      chk({dualPortRoute, toVme, longWidth}, cmd[6:4]);
      i = 0;
      while (rv[7] && i < 600) begin
        rd(`OFF_LOCAL_CMD, rv);
        i = i + 1;
      end
      chk(rv, {1'b0, cmd[6:4], 1'b0, cmd[2], 2'b10});
      chk(hostAddr, 24'h031200 + 24'd264);
      chk(vmeAddr, 32'h01024000 + 32'd264);
      chk(doneIrq, cmd[2] & normalIrqEnable);
      chk(gapCnt > 1, mode[5]);
      rd(`OFF_PACKETS_LOW, rv);
      chk(rv, 8'h00);
      wr(`OFF_LOCAL_CMD, 8'h00);
      chk(doneIrq, 1'b0);
      rd(`OFF_LOCAL_CMD, rv);
      chk(rv[1], 1'b0);
      wr(`OFF_REMOTE_MODE, mode);
    end
  endtask
  task t_timeout;
    begin
      stall = 1'b1;
      wr(`OFF_REMOTE_MODE, 8'h10);
      wr(`OFF_LOCAL_REMAINDER, 8'h08);
      wr(`OFF_LOCAL_CMD, 8'h90);
      repeat (LIMIT + 10) @(posedge core_clk);
      #1 chk(vmeRequest, 1'b0);
      rd(`OFF_TARGET_ERR, rv);
      chk(rv[`ERR_TIMEOUT_BIT], 1'b1);
      rd(`OFF_LOCAL_CMD, rv);
      chk({rv[7], rv[0]}, 2'b00);
      stall = 1'b0;
      wr(`OFF_TARGET_ERR, 8'h80);
    end
  endtask
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  initial begin
    {rst, regWrite, regRead, regWordRead, stall, badAck} = 6'b100000;
    {normalIrqEnable, remoteIrqIn, remoteDmaBusy} = 3'b000;
    regAddr = 5'h00;
    regWrData = 8'h00;
    error_cnt = 0;
    n_checks = 0;
    gapCnt = 0;
    repeat (8) @(posedge core_clk);
    #1 rst = 1'b0;
    t_misc;
    t_iack;
    normalIrqEnable = 1'b1;
    t_dma(8'ha0, 8'h04, 8'h0f);
    t_dma(8'h20, 8'h74, 8'h0b);
    normalIrqEnable = 1'b0;
    t_dma(8'h80, 8'h24, 8'h09);
    t_timeout;
    tally_and_finish;
  end
  initial begin
    #2000000;
    error_cnt = error_cnt + 1;
    tally_and_finish;
  end
endmodule // bus_adapter_dma_control_tb
